// ==== hdl/scratchpad_memory_commands.sv ====
// Memory function command layer: scratchpad write/read, copy, read memory
`timescale 1ns/1ps
`include "scratchpad_memory_commands_defines.svh"

// Summary of operation
// - Store data from T offset; E tracks last byte
// - Incomplete last byte dropped, partial flag set
// - Address cut short sets partial flag
// - Full address clears partial and bad-sequence flags
// - CRC16 over command, raw address, data bytes
// - At offset 1Fh, read slots return inverted CRC
// - Write-protected target loads memory contents
// - OTP page loads AND of data and memory
// - Upper four address bits forced to zero
// - Read sends address, status, then scratchpad data
// - Then inverted CRC, afterwards all ones
// - Copy only on match, valid, clean flags
// - Copy start through ending offset to memory
// - After copy, answer alternating zero and one
// - Read memory streams to 0A3Fh, then FFh
// - Read memory sets bad-sequence flag
// - Standard speed unless overdrive explicitly set
// - Status byte is AA, 0, PF, offset
// - Scratchpad data write clears authorization flag
// - 55h write-protects, AAh is OTP mode
module scratchpad_memory_commands #(
    parameter int PROG_INTERVAL_US = `PROG_INTERVAL_US
) (
    input  wire logic                                  core_clk,
    input  wire logic                                  rst,
    input  wire scratchpad_memory_commands_pkg::link_in_t  link_in,
    output scratchpad_memory_commands_pkg::link_out_t      link_out,
    output scratchpad_memory_commands_pkg::mem_req_t       mem_out,
    input  wire logic                                  mem_ack,
    input  wire logic [7:0]                            mem_rdata,
    output logic [3:0]                                 prot_block,
    input  wire logic [7:0]                            prot_code,
    input  wire logic                                  copy_protect,
    output scratchpad_memory_commands_pkg::status_t        status
);
    import scratchpad_memory_commands_pkg::*;

    localparam int PROG_CYCLES = PROG_INTERVAL_US * `CLK_MHZ;

    if (PROG_INTERVAL_US < 1) begin : g_bad_prog
        $error("program interval below 1 us");
    end

    typedef struct packed {
        cmd_state_t  state;
        logic [23:0] rx;
        logic [4:0]  rx_cnt;
        logic [7:0]  tx;
        logic [3:0]  tx_left;
        logic        crc_tx;
        logic        rd_pend;
        logic [7:0]  ta_lo;
        logic [7:0]  ta_hi;
        logic [4:0]  ptr;
        logic [2:0]  idx;
        logic [7:0]  pend;
        logic [15:0] rm_addr;
        logic [31:0] prog_cnt;
        logic        alt;
        logic        abort;
        logic [3:0]  prot_block;
        status_t     st;
        link_out_t   lo;
        mem_req_t    mem;
    } core_t;

    core_t       c_q;
    core_t       c_d;
    logic        crc_clr;
    logic        crc_en;
    logic        crc_bit;
    logic [15:0] crc;
    logic        sp_we;
    logic [7:0]  sp_wdata;
    logic [7:0]  sp_rdata;
    logic [23:0] rx_new;
    logic        commit;
    logic [7:0]  commit_byte;
    logic [7:0]  es_byte;
    logic        prot_any;

    crc16_serial u_crc (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (crc_clr),
        .shift_en (crc_en),
        .bit_in   (crc_bit),
        .crc      (crc)
    );

    scratchpad_store #(
        .DEPTH (32),
        .WIDTH (8)
    ) u_sp (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (sp_we),
        .wr_idx   (c_q.ptr),
        .wr_data  (sp_wdata),
        .rd_idx   (c_d.ptr),
        .rd_data  (sp_rdata)
    );

    // Command sequencer; all state advances in one place
    always_comb begin
        c_d         = c_q;
        crc_clr     = 1'b0;
        crc_en      = 1'b0;
        crc_bit     = 1'b0;
        commit      = 1'b0;
        commit_byte = 8'h00;
        sp_we       = 1'b0;
        sp_wdata    = 8'h00;
        rx_new      = {link_in.wr_bit, c_q.rx[23:1]};
        es_byte     = {c_q.st.aa, 1'b0, c_q.st.pf, c_q.st.end_off};
        prot_any    = (prot_code == `PROT_WRITE) || (prot_code == `PROT_OTP);
        c_d.lo.rd_valid = 1'b0;
        if (link_in.rd_slot) begin
            c_d.rd_pend = 1'b1;
        end
        // Speed flag: set only by overdrive
        if (link_in.od_set) begin
            c_d.st.od = 1'b1;
        end else if (link_in.std_reset) begin
            c_d.st.od = 1'b0;
        end
        // Serialiser: one bit per pending read slot, LSB first
        if (c_q.rd_pend && c_q.tx_left != 4'd0) begin
            c_d.lo.rd_valid = 1'b1;
            c_d.lo.rd_bit   = c_q.tx[0];
            c_d.tx          = {1'b1, c_q.tx[7:1]};
            c_d.tx_left     = c_q.tx_left - 4'd1;
            c_d.rd_pend     = link_in.rd_slot;
            crc_en          = c_q.crc_tx;
            crc_bit         = c_q.tx[0];
        end
        // Deserialiser
        if (link_in.wr_valid) begin
            c_d.rx     = rx_new;
            c_d.rx_cnt = c_q.rx_cnt + 5'd1;
        end
        // Command and write-scratchpad bits feed the CRC
        if (link_in.wr_valid &&
            c_q.state inside {ST_CMD, ST_WS_ADDR, ST_WS_DATA, ST_WS_FETCH}) begin
            crc_en  = 1'b1;
            crc_bit = link_in.wr_bit;
        end
        // Receive states, the programming wait and ST_ONES answer read slots with an idle one
        if (c_q.rd_pend && c_q.state inside {ST_CMD, ST_WS_ADDR, ST_WS_DATA, ST_CP_AUTH,
                                             ST_RM_ADDR, ST_CP_PROG, ST_ONES}) begin
            c_d.lo.rd_valid = 1'b1;
            c_d.lo.rd_bit   = 1'b1;
            c_d.rd_pend     = link_in.rd_slot;
        end
        unique case (c_q.state)
            ST_IDLE: begin
                c_d.rd_pend = 1'b0;
                if (link_in.cmd_start) begin
                    c_d.state   = ST_CMD;
                    c_d.rx_cnt  = 5'd0;
                    c_d.tx_left = 4'd0;
                    c_d.crc_tx  = 1'b0;
                    c_d.abort   = 1'b0;
                    crc_clr     = 1'b1;
                end
            end
            ST_CMD: begin
                if (link_in.wr_valid && c_q.rx_cnt == 5'd7) begin
                    c_d.rx_cnt = 5'd0;
                    c_d.idx    = 3'd0;
                    // Only read scratchpad folds sent bits into the CRC
                    c_d.crc_tx = (rx_new[23:16] == `CMD_READ_SP);
                    c_d.ptr    = c_q.ta_lo[4:0];
                    unique case (rx_new[23:16])
                        `CMD_WRITE_SP: c_d.state = ST_WS_ADDR;
                        `CMD_READ_SP:  c_d.state = ST_RS_TX;
                        `CMD_COPY_SP:  c_d.state = ST_CP_AUTH;
                        `CMD_READ_MEM: begin
                            c_d.state = ST_RM_ADDR;
                            c_d.st.bs = 1'b1;
                        end
                        default:       c_d.state = ST_ONES;
                    endcase
                end
            end
            ST_WS_ADDR: begin
                if (link_in.wr_valid && c_q.rx_cnt == 5'd15) begin
                    c_d.ta_lo      = rx_new[15:8];
                    c_d.ta_hi      = {4'h0, rx_new[19:16]};
                    c_d.prot_block = rx_new[19:16];
                    c_d.ptr        = rx_new[12:8];
                    c_d.st.end_off = rx_new[12:8];
                    c_d.st.pf      = 1'b0;
                    c_d.st.bs      = 1'b0;
                    c_d.rx_cnt     = 5'd0;
                    c_d.state      = ST_WS_DATA;
                end
            end
            ST_WS_DATA: begin
                if (link_in.wr_valid && c_q.rx_cnt == 5'd7) begin
                    c_d.rx_cnt = 5'd0;
                    if (prot_any) begin
                        // Protected target: fetch stored byte first
                        c_d.pend      = rx_new[23:16];
                        c_d.mem.req   = 1'b1;
                        c_d.mem.we    = 1'b0;
                        c_d.mem.addr  = {c_q.ta_hi, c_q.ta_lo[7:5], c_q.ptr};
                        c_d.state     = ST_WS_FETCH;
                    end else begin
                        commit      = 1'b1;
                        commit_byte = rx_new[23:16];
                    end
                end
            end
            ST_WS_FETCH: begin
                if (mem_ack) begin
                    c_d.mem.req = 1'b0;
                    commit      = 1'b1;
                    if (prot_code == `PROT_WRITE) begin
                        commit_byte = mem_rdata;
                    end else begin
                        commit_byte = c_q.pend & mem_rdata;
                    end
                    if (c_q.abort) begin
                        c_d.state = ST_IDLE;
                    end
                end
            end
            ST_WS_CRC: begin
                if (c_q.rd_pend && c_q.tx_left == 4'd0) begin
                    c_d.idx = c_q.idx + 3'd1;
                    unique case (c_q.idx)
                        3'd0:    {c_d.tx, c_d.tx_left} = {~crc[7:0], 4'd8};
                        3'd1:    {c_d.tx, c_d.tx_left} = {~crc[15:8], 4'd8};
                        default: c_d.state = ST_ONES;
                    endcase
                end
            end
            ST_RS_TX: begin
                if (c_q.rd_pend && c_q.tx_left == 4'd0) begin
                    c_d.tx_left = 4'd8;
                    c_d.idx     = c_q.idx + 3'd1;
                    unique case (c_q.idx)
                        3'd0: c_d.tx = c_q.ta_lo;
                        3'd1: c_d.tx = c_q.ta_hi;
                        3'd2: c_d.tx = es_byte;
                        3'd3: begin
                            // Scratchpad read port already holds the byte at ptr
                            c_d.tx = sp_rdata;
                            if (c_q.ptr != `OFFSET_LAST) begin
                                c_d.idx = 3'd3;
                                c_d.ptr = c_q.ptr + 5'd1;
                            end
                        end
                        3'd4: begin
                            c_d.tx     = ~crc[7:0];
                            c_d.crc_tx = 1'b0;
                        end
                        3'd5: c_d.tx = ~crc[15:8];
                        default: begin
                            c_d.tx_left = 4'd0;
                            c_d.state   = ST_ONES;
                        end
                    endcase
                end
            end
            ST_CP_AUTH: begin
                if (link_in.wr_valid && c_q.rx_cnt == 5'd23) begin
                    // Refusal leaves the authorization flag untouched
                    if (rx_new == {es_byte, c_q.ta_hi, c_q.ta_lo} &&
                        {c_q.ta_hi, c_q.ta_lo} <= `ADDR_LAST && !c_q.st.pf &&
                        !c_q.st.bs && !copy_protect) begin
                        c_d.st.aa = 1'b1;
                        c_d.ptr   = c_q.ta_lo[4:0];
                        c_d.state = ST_CP_RD;
                    end else begin
                        c_d.state = ST_ONES;
                    end
                end
            end
            ST_CP_RD: begin
                // Read port already shows the byte at ptr
                c_d.mem.req   = 1'b1;
                c_d.mem.we    = 1'b1;
                c_d.mem.addr  = {c_q.ta_hi, c_q.ta_lo[7:5], c_q.ptr};
                c_d.mem.wdata = sp_rdata;
                c_d.state     = ST_CP_WR;
            end
            ST_CP_WR: begin
                if (mem_ack) begin
                    c_d.mem.req = 1'b0;
                    if (c_q.ptr == c_q.st.end_off) begin
                        c_d.prog_cnt = 32'd0;
                        c_d.state    = ST_CP_PROG;
                    end else begin
                        c_d.ptr   = c_q.ptr + 5'd1;
                        c_d.state = ST_CP_RD;
                    end
                end
            end
            ST_CP_PROG: begin
                // Line is expected idle here; the copy cannot be cut short
                c_d.prog_cnt = c_q.prog_cnt + 32'd1;
                if (c_q.prog_cnt == 32'(PROG_CYCLES - 1)) begin
                    c_d.alt   = 1'b0;
                    c_d.state = c_q.abort ? ST_IDLE : ST_CP_DONE;
                end
            end
            ST_CP_DONE: begin
                if (c_q.rd_pend) begin
                    c_d.lo.rd_valid = 1'b1;
                    c_d.lo.rd_bit   = c_q.alt;
                    c_d.alt         = ~c_q.alt;
                    c_d.rd_pend     = link_in.rd_slot;
                end
            end
            ST_RM_ADDR: begin
                if (link_in.wr_valid && c_q.rx_cnt == 5'd15) begin
                    c_d.rm_addr = {4'h0, rx_new[19:16], rx_new[15:8]};
                    c_d.crc_tx  = 1'b0;
                    c_d.state   = ST_RM_TX;
                end
            end
            ST_RM_TX: begin
                if (c_q.rd_pend && c_q.tx_left == 4'd0) begin
                    if (c_q.rm_addr > `ADDR_LAST) begin
                        c_d.tx      = `FILL_BYTE;
                        c_d.tx_left = 4'd8;
                    end else begin
                        c_d.mem.req  = 1'b1;
                        c_d.mem.we   = 1'b0;
                        c_d.mem.addr = c_q.rm_addr;
                        c_d.state    = ST_RM_FETCH;
                    end
                end
            end
            ST_RM_FETCH: begin
                if (mem_ack) begin
                    c_d.mem.req = 1'b0;
                    c_d.tx      = mem_rdata;
                    c_d.tx_left = 4'd8;
                    c_d.rm_addr = c_q.rm_addr + 16'd1;
                    c_d.state   = c_q.abort ? ST_IDLE : ST_RM_TX;
                end
            end
            ST_ONES: begin
            end
        endcase
        // Full byte lands in the scratchpad; offset 1Fh ends intake
        if (commit) begin
            sp_we          = 1'b1;
            sp_wdata       = commit_byte;
            c_d.st.end_off = c_q.ptr;
            c_d.st.aa      = 1'b0;
            if (c_q.ptr == `OFFSET_LAST) begin
                c_d.idx   = 3'd0;
                c_d.state = (c_q.state == ST_WS_FETCH && c_q.abort) ? ST_IDLE : ST_WS_CRC;
            end else begin
                c_d.ptr   = c_q.ptr + 5'd1;
                c_d.state = (c_q.state == ST_WS_FETCH && c_q.abort) ? ST_IDLE : ST_WS_DATA;
            end
        end
        // Reset pulse: memory fetches and the whole copy with its programming wait finish first, others stop at once
        if (link_in.reset_pulse && c_q.state != ST_IDLE) begin
            if (c_q.state == ST_WS_ADDR) begin
                c_d.st.pf = 1'b1;
            end
            if (c_q.state == ST_WS_DATA && c_q.rx_cnt != 5'd0) begin
                c_d.st.pf = 1'b1;
            end
            c_d.rd_pend = 1'b0;
            c_d.tx_left = 4'd0;
            if (c_q.state inside {ST_WS_FETCH, ST_CP_RD, ST_CP_WR, ST_CP_PROG, ST_RM_FETCH}) begin
                c_d.abort = 1'b1;
            end else begin
                c_d.state = ST_IDLE;
            end
        end
    end

    // Single state register; flags start as after power loss
    always_ff @(posedge core_clk) begin
        if (rst) begin
            c_q       <= '0;
            c_q.st.pf <= `PF_RESET;
            c_q.st.aa <= `AA_RESET;
            c_q.st.bs <= `BS_RESET;
            c_q.st.od <= `OD_RESET;
        end else begin
            c_q <= c_d;
        end
    end

    assign link_out   = c_q.lo;
    assign mem_out    = c_q.mem;
    assign prot_block = c_q.prot_block;
    assign status     = c_q.st;
endmodule

// ==== hdl/scratchpad_memory_commands_defines.svh ====
// Constants of the scratchpad memory command layer
`ifndef SCRATCHPAD_MEMORY_COMMANDS_DEFINES_SVH
`define SCRATCHPAD_MEMORY_COMMANDS_DEFINES_SVH

// Command codes
`define CMD_WRITE_SP      8'h0F
`define CMD_READ_SP       8'hAA
`define CMD_COPY_SP       8'h55
`define CMD_READ_MEM      8'hF0

// Address space and fill values
`define ADDR_LAST         16'h0A3F
`define FILL_BYTE         8'hFF
`define OFFSET_LAST       5'h1F

// Block protection codes
`define PROT_WRITE        8'h55
`define PROT_OTP          8'hAA

// CRC16 x16+x15+x2+1, reversed for LSB first
`define CRC_POLY_REV      16'hA001
`define CRC_RESET         16'h0000

// Flag reset values
`define PF_RESET          1'b1
`define AA_RESET          1'b0
`define BS_RESET          1'b0
`define OD_RESET          1'b0

// Timing
`define CLK_MHZ           250
`define PROG_INTERVAL_US  10000

`endif

// ==== hdl/scratchpad_memory_commands_pkg.sv ====
// Types shared by the scratchpad memory command layer
package scratchpad_memory_commands_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_CMD, ST_WS_ADDR, ST_WS_DATA, ST_WS_FETCH, ST_WS_CRC,
        ST_RS_TX, ST_CP_AUTH, ST_CP_RD, ST_CP_WR, ST_CP_PROG, ST_CP_DONE,
        ST_RM_ADDR, ST_RM_TX, ST_RM_FETCH, ST_ONES
    } cmd_state_t;

    // Bit-level events from the link layer
    typedef struct packed {
        logic reset_pulse;
        logic std_reset;
        logic od_set;
        logic cmd_start;
        logic wr_valid;
        logic wr_bit;
        logic rd_slot;
    } link_in_t;

    // Answer to a read slot
    typedef struct packed {
        logic rd_valid;
        logic rd_bit;
    } link_out_t;

    // Byte request to the nonvolatile memory
    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;

    // Transfer status
    typedef struct packed {
        logic       aa;
        logic       pf;
        logic       bs;
        logic       od;
        logic [4:0] end_off;
    } status_t;

endpackage

// ==== hdl/crc16_serial.sv ====
// Bit-serial CRC16 generator, LSB first
`timescale 1ns/1ps
`include "scratchpad_memory_commands_defines.svh"
module crc16_serial (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clear,
    input  wire logic        shift_en,
    input  wire logic        bit_in,
    output logic [15:0]      crc
);
    typedef struct packed {
        logic [15:0] crc;
    } crc_state_t;

    crc_state_t s_q;
    crc_state_t s_d;
    logic       fb;

    // Clear wins over a shift in the same cycle
    always_comb begin
        s_d = s_q;
        fb  = bit_in ^ s_q.crc[0];
        if (clear) begin
            s_d.crc = `CRC_RESET;
        end else if (shift_en) begin
            s_d.crc = {1'b0, s_q.crc[15:1]} ^ (fb ? `CRC_POLY_REV : 16'h0000);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q.crc <= `CRC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign crc = s_q.crc;
endmodule

// ==== hdl/scratchpad_store.sv ====
// Scratchpad storage in flip-flops with a registered read port
`timescale 1ns/1ps
module scratchpad_store #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 8
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [WIDTH-1:0]              rd_data
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rd;
    } sp_state_t;

    sp_state_t                   s_q;
    sp_state_t                   s_d;
    logic [DEPTH-1:0][WIDTH-1:0] mem_nxt;

    // Index width must cover the depth exactly
    if (DEPTH < 2 || (1 << $clog2(DEPTH)) != DEPTH) begin : g_bad_depth
        $error("depth not a power of two");
    end

    // One write decoder per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        assign mem_nxt[i] = (wr_en && wr_idx == i) ? wr_data : s_q.mem[i];
    end

    // Read returns the entry selected one cycle earlier
    always_comb begin
        s_d     = s_q;
        s_d.mem = mem_nxt;
        s_d.rd  = s_q.mem[rd_idx];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd;
endmodule

// ==== tb/scratchpad_memory_commands_monitor.sv ====
// Port checker of the scratchpad memory command layer
`timescale 1ns/1ps
module scratchpad_memory_commands_monitor (
    input wire logic                                      core_clk,
    input wire logic                                      rst,
    input wire scratchpad_memory_commands_pkg::link_in_t  link_in,
    input wire scratchpad_memory_commands_pkg::link_out_t link_out,
    input wire scratchpad_memory_commands_pkg::mem_req_t  mem_out,
    input wire logic                                      mem_ack,
    input wire logic                                      copy_protect,
    input wire scratchpad_memory_commands_pkg::status_t   status
);
    // All checks share the one clock and the synchronous reset
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_od_set; link_in.od_set |=> status.od; endproperty
    a_od_set: assert property (p_od_set) else $error("speed flag not set");
    property p_od_clr; link_in.std_reset && !link_in.od_set |=> !status.od; endproperty
    a_od_clr: assert property (p_od_clr) else $error("speed flag not cleared");
    property p_rd_one; link_out.rd_valid |=> !link_out.rd_valid; endproperty
    a_rd_one: assert property (p_rd_one) else $error("answer too long");
    property p_hold; mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out.addr); endproperty
    a_hold: assert property (p_hold) else $error("memory request dropped");
    property p_drop; mem_ack |-> ##[1:2] !mem_out.req; endproperty
    a_drop: assert property (p_drop) else $error("request kept after ack");
    property p_addr; mem_out.req |-> mem_out.addr <= 16'h0A3F; endproperty
    a_addr: assert property (p_addr) else $error("address out of range");
    property p_wr; mem_out.req && mem_out.we |-> status.aa && !status.bs && !status.pf;
    endproperty
    a_wr: assert property (p_wr) else $error("unauthorized copy");
    property p_aa; $rose(status.aa) |-> !status.pf && !status.bs && !$past(copy_protect);
    endproperty
    a_aa: assert property (p_aa) else $error("bad auth flag");
    // Main scenarios reached
    c_copy: cover property (mem_out.req && mem_out.we && mem_ack);
    c_aa: cover property ($rose(status.aa));
    c_zero: cover property (link_out.rd_valid && !link_out.rd_bit);
endmodule
bind scratchpad_memory_commands scratchpad_memory_commands_monitor mon (.core_clk(core_clk),
    .rst(rst), .link_in(link_in), .link_out(link_out), .mem_out(mem_out), .mem_ack(mem_ack),
    .copy_protect(copy_protect), .status(status));

// ==== tb/nv_memory_model.sv ====
// Nonvolatile byte memory answering requests after a fixed delay
`timescale 1ns/1ps
module nv_memory_model #(
    parameter int LAT = 3
) (
    input  wire logic                                     core_clk,
    input  wire scratchpad_memory_commands_pkg::mem_req_t mem_out,
    output logic                                          mem_ack,
    output logic [7:0]                                    mem_rdata
);
    logic [7:0] mem [0:16'h0A3F];
    int         wait_q = 0;
    logic       hit;
    assign hit = mem_out.req && wait_q == LAT;
    // Known contents so that reads can be predicted
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 8'hFF;
        for (int a = 0; a <= 16'h0A3F; a++) begin
            mem[a] = a[7:0] ^ 8'h5A;
        end
    end
    // Data toggles off the ack cycle so stale data shows
    always @(posedge core_clk) begin
        mem_ack <= hit;
        wait_q <= (mem_out.req && wait_q < LAT) ? wait_q + 1 : 0;
        mem_rdata <= hit ? mem[mem_out.addr] : ~mem_rdata;
        if (hit && mem_out.we) begin
            mem[mem_out.addr] <= mem_out.wdata;
        end
    end
endmodule

// ==== tb/scratchpad_memory_commands_test.sv ====
// Testbench of the scratchpad memory command layer
`timescale 1ns/1ps
module scratchpad_memory_commands_test;
    import scratchpad_memory_commands_pkg::*;
    logic        core_clk = 0;
    logic        rst = 1;
    link_in_t    li = '0;
    link_out_t   lo;
    mem_req_t    mo;
    status_t     st;
    logic        mem_ack;
    logic [7:0]  mem_rdata;
    logic [3:0]  prot_block;
    logic [7:0]  prot_code = 8'h00;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [15:0] c;
    logic [15:0] e;
    logic [7:0]  v;
    always #2 core_clk = ~core_clk;
    scratchpad_memory_commands #(.PROG_INTERVAL_US(1)) dut (.core_clk(core_clk), .rst(rst),
        .link_in(li), .link_out(lo), .mem_out(mo), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .prot_block(prot_block), .prot_code(prot_code), .copy_protect(1'b0), .status(st));
    nv_memory_model nvm (.core_clk(core_clk), .mem_out(mo), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    // Hang guard
    always @(posedge core_clk) begin
        if (++cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] crc(input logic [15:0] s, input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            s = (s[0] ^ b[i]) ? (s >> 1) ^ 16'hA001 : s >> 1;
        end
        return s;
    endfunction
    // One link event, then a quiet cycle
    task ev(input logic [6:0] m);
        @(posedge core_clk);
        li <= m;
        @(posedge core_clk);
        li <= '0;
        @(posedge core_clk);
    endtask
    task wb(input logic [7:0] b);
        for (int i = 0; i < 8; i++) ev({5'b00001, b[i], 1'b0});
        c = crc(c, b);
    endtask
    task rb(input logic [7:0] exp);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            li <= 7'h01;
            @(posedge core_clk);
            li <= '0;
            for (int k = 0; k < 40 && !lo.rd_valid; k++) @(negedge core_clk);
            v = {lo.rd_bit, v[7:1]};
        end
        chk(v, exp);
        c = crc(c, exp);
    endtask
    task start(input logic [7:0] cmd);
        ev(7'h40);
        ev(7'h08);
        c = 16'h0000;
        wb(cmd);
    endtask
    task t_speed;
        ev(7'h10);
        chk(st.od, 1'b1);
        ev(7'h20);
        chk(st.od, 1'b0);
    endtask
    task t_partial;
        start(8'h0F);
        wb(8'h12);
        ev(7'h40);
        chk(st.pf, 1'b1);
        start(8'h0F);
        wb(8'h00);
        wb(8'h00);
        chk(st.pf, 1'b0);
        for (int i = 0; i < 3; i++) ev(7'h04);
        ev(7'h40);
        chk(st.pf, 1'b1);
    endtask
    task t_write;
        start(8'h0F);
        wb(8'h1E);
        wb(8'hF1);
        wb(8'h3C);
        wb(8'hC3);
        chk({7'b0, st}, 16'h001F);
        e = ~c;
        rb(e[7:0]);
        rb(e[15:8]);
    endtask
    task t_read;
        start(8'hAA);
        rb(8'h1E);
        rb(8'h01);
        rb(8'h1F);
        rb(8'h3C);
        rb(8'hC3);
        e = ~c;
        rb(e[7:0]);
        rb(e[15:8]);
        rb(8'hFF);
    endtask
    task t_copy;
        start(8'h55);
        wb(8'h1E);
        wb(8'h01);
        wb(8'h1F);
        repeat (400) @(posedge core_clk);
        chk(st.aa, 1'b1);
        chk(nvm.mem[16'h011E], 8'h3C);
        chk(nvm.mem[16'h011F], 8'hC3);
        rb(8'hAA);
    endtask
    task t_rmem;
        start(8'hF0);
        wb(8'h3F);
        wb(8'hFA);
        chk(st.bs, 1'b1);
        rb(8'h65);
        rb(8'hFF);
        start(8'h55);
        wb(8'h1E);
        wb(8'h01);
        wb(8'h9F);
        rb(8'hFF);
    endtask
    // Protected block loads memory, OTP the AND
    task t_prot;
        for (int k = 0; k < 2; k++) begin
            prot_code <= k ? 8'hAA : 8'h55;
            start(8'h0F);
            wb(8'h3F);
            wb(8'h00);
            wb(8'h0F);
            chk(prot_block, 4'h0);
            start(8'hAA);
            rb(8'h3F);
            rb(8'h00);
            rb(8'h1F);
            rb(k ? 8'h05 : 8'h65);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk({7'b0, st}, 16'h0080);
        t_speed();
        t_partial();
        t_write();
        t_read();
        t_copy();
        t_rmem();
        t_prot();
        finish_test();
    end
endmodule
